// ===== src/gpxt_pkg.sv
// package: constants and state layout for the gpio expander tail block
package gpxt_pkg;
  localparam int unsigned GPXT_PINS = 8;
  // register offsets
  localparam logic [7:0] GPXT_ADDR_PIN4_TABLE = 8'h2b;
  localparam logic [7:0] GPXT_ADDR_ADVANCED = 8'had;
  localparam logic [7:0] GPXT_ADDR_DATA_HIGH = 8'h10;
  localparam logic [7:0] GPXT_ADDR_DATA_LOW = 8'h11;
  localparam logic [7:0] GPXT_ADDR_IRQ_MASK = 8'h12;
  localparam logic [7:0] GPXT_ADDR_EDGE_UPPER = 8'h13;
  localparam logic [7:0] GPXT_ADDR_EDGE_LOWER = 8'h14;
  localparam logic [7:0] GPXT_ADDR_IRQ_SOURCE = 8'h15;
  localparam logic [7:0] GPXT_ADDR_EVENT = 8'h16;
  // reset values
  localparam logic [7:0] GPXT_RST_PIN4_TABLE = 8'h00;
  localparam logic [7:0] GPXT_RST_ADVANCED = 8'h00;
  localparam logic [7:0] GPXT_RST_IRQ_MASK = 8'hff;
  localparam logic [7:0] GPXT_RST_EDGE = 8'h00;
  localparam logic [7:0] GPXT_RST_FLAGS = 8'h00;
  // advanced options fields; bit 0 and bits 7:3 are reserved
  localparam int unsigned GPXT_ADV_AUTOCLR_BIT = 2;
  localparam int unsigned GPXT_ADV_BOOST_BIT = 1;
  localparam logic [7:0] GPXT_ADV_WMASK = 8'h06;
  // low bank logic mode code for the 3-to-2 function
  localparam int unsigned GPXT_MODE_W = 2;
  localparam logic [GPXT_MODE_W-1:0] GPXT_MODE_3TO2 = 2'h3;
  // two-bit edge select codes
  typedef enum logic [1:0] {
    GPXT_EDGE_NONE = 2'b00,
    GPXT_EDGE_RISE = 2'b01,
    GPXT_EDGE_FALL = 2'b10,
    GPXT_EDGE_BOTH = 2'b11
  } gpxt_edge_t;
  typedef struct packed {
    logic [7:0] table_v;
    logic [7:0] adv;
    logic [7:0] mask;
    logic [7:0] edge_upper;
    logic [7:0] edge_lower;
    logic [7:0] src;
    logic [7:0] evt;
    logic [7:0] prev_pins;
    logic [7:0] rdata;
    logic pin4_out;
    logic pin4_drive;
    logic irq_n;
    logic boost;
  } gpxt_state_t;
endpackage

// ===== src/gpxt_edge.sv
// per-pin edge detector with two-bit edge select
`timescale 1ns/1ps
`default_nettype none
module gpxt_edge
  import gpxt_pkg::*;
(
  // pin samples
  input wire logic prev,
  input wire logic cur,
  // edge select
  input wire logic [1:0] sel,
  // detected edge
  output logic hit
);
  logic rise;
  logic fall;
  assign rise = !prev && cur;
  assign fall = prev && !cur;
  always_comb
  begin
    case (sel)
      GPXT_EDGE_NONE: hit = 1'b0;
      GPXT_EDGE_RISE: hit = rise;
      GPXT_EDGE_FALL: hit = fall;
      GPXT_EDGE_BOTH: hit = rise || fall;
      default: hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== src/gpxt_top.sv
// gpio expander tail: pin 4 logic table, advanced options, interrupt flags
`timescale 1ns/1ps
`default_nettype none
module gpxt_top
  import gpxt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access from the serial interface logic
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins and mode
  input wire logic [15:0] pins_in,
  input wire logic [GPXT_MODE_W-1:0] low_bank_logic_mode,
  // outputs
  output logic pin4_out,
  output logic pin4_drive,
  output logic boost_on,
  output logic irq_out_n
);
  gpxt_state_t s_q;
  gpxt_state_t s_d;
  logic [7:0] hits;
  logic [7:0] src_set;
  logic [15:0] edge_sel;
  logic pin4_pick;
  logic data_rd;
  logic autoclr;

  assign edge_sel = {s_q.edge_upper, s_q.edge_lower};

  genvar gi;
  generate
    for (gi = 0; gi < GPXT_PINS; gi++)
    begin : g_edge
      gpxt_edge u_edge (
        .prev(s_q.prev_pins[gi]),
        .cur(pins_in[gi]),
        .sel(edge_sel[2*gi +: 2]),
        .hit(hits[gi])
      );
    end
  endgenerate

  assign src_set = hits & ~s_q.mask;
  assign pin4_pick = s_q.table_v[pins_in[2:0]];
  assign autoclr = s_q.adv[GPXT_ADV_AUTOCLR_BIT];
  assign data_rd = reg_rd
    && (reg_addr == GPXT_ADDR_DATA_HIGH || reg_addr == GPXT_ADDR_DATA_LOW);

  always_comb
  begin
    s_d = s_q;
    s_d.prev_pins = pins_in[7:0];
    s_d.pin4_drive = (low_bank_logic_mode == GPXT_MODE_3TO2);
    s_d.pin4_out = (low_bank_logic_mode == GPXT_MODE_3TO2) ? pin4_pick : 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        GPXT_ADDR_PIN4_TABLE: s_d.table_v = reg_wdata;
        // boost and auto-clear bits stored, reserved bits held zero
        GPXT_ADDR_ADVANCED: s_d.adv = reg_wdata & GPXT_ADV_WMASK;
        GPXT_ADDR_IRQ_MASK: s_d.mask = reg_wdata;
        GPXT_ADDR_EDGE_UPPER: s_d.edge_upper = reg_wdata;
        GPXT_ADDR_EDGE_LOWER: s_d.edge_lower = reg_wdata;
        GPXT_ADDR_IRQ_SOURCE: s_d.src = s_q.src & ~reg_wdata;
        GPXT_ADDR_EVENT:
        begin
          s_d.evt = s_q.evt & ~reg_wdata;
          s_d.src = s_q.src & ~reg_wdata;
        end
        default: s_d.adv = s_q.adv;
      endcase
    end
    // auto-clear on either bank data read
    if (data_rd && autoclr)
      s_d.src = GPXT_RST_FLAGS;
    // new edges win over any clear in the same cycle
    s_d.src = s_d.src | src_set;
    s_d.evt = s_d.evt | hits;
    s_d.boost = s_d.adv[GPXT_ADV_BOOST_BIT];
    s_d.irq_n = ~|s_q.src;
    s_d.rdata = s_q.rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        GPXT_ADDR_PIN4_TABLE: s_d.rdata = s_q.table_v;
        GPXT_ADDR_ADVANCED: s_d.rdata = s_q.adv;
        GPXT_ADDR_DATA_HIGH: s_d.rdata = pins_in[15:8];
        GPXT_ADDR_DATA_LOW: s_d.rdata = pins_in[7:0];
        GPXT_ADDR_IRQ_MASK: s_d.rdata = s_q.mask;
        GPXT_ADDR_EDGE_UPPER: s_d.rdata = s_q.edge_upper;
        GPXT_ADDR_EDGE_LOWER: s_d.rdata = s_q.edge_lower;
        GPXT_ADDR_IRQ_SOURCE: s_d.rdata = s_q.src;
        GPXT_ADDR_EVENT: s_d.rdata = s_q.evt;
        default: s_d.rdata = GPXT_RST_FLAGS;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q.table_v <= GPXT_RST_PIN4_TABLE;
      s_q.adv <= GPXT_RST_ADVANCED;
      s_q.mask <= GPXT_RST_IRQ_MASK;
      s_q.edge_upper <= GPXT_RST_EDGE;
      s_q.edge_lower <= GPXT_RST_EDGE;
      s_q.src <= GPXT_RST_FLAGS;
      s_q.evt <= GPXT_RST_FLAGS;
      s_q.prev_pins <= GPXT_RST_FLAGS;
      s_q.rdata <= GPXT_RST_FLAGS;
      s_q.pin4_out <= 1'b0;
      s_q.pin4_drive <= 1'b0;
      s_q.irq_n <= 1'b1;
      s_q.boost <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign pin4_out = s_q.pin4_out;
  assign pin4_drive = s_q.pin4_drive;
  assign boost_on = s_q.boost;
  assign irq_out_n = s_q.irq_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_PIN4_TABLE: assert property (
    low_bank_logic_mode == GPXT_MODE_3TO2 |=> pin4_out == $past(pin4_pick))
    else $error("pin 4 does not follow the logic table");

  AST_PIN4_MODE_GATE: assert property (
    low_bank_logic_mode != GPXT_MODE_3TO2 |=> !pin4_drive && !pin4_out)
    else $error("pin 4 driven outside 3-to-2 mode");

  AST_READ_KEEPS_FLAGS: assert property (
    (data_rd && !autoclr && !reg_wr) |=> (s_q.src & $past(s_q.src)) == $past(s_q.src))
    else $error("data read cleared flags with auto-clear off");

  AST_FLAGS_STICKY: assert property (
    (!reg_wr && !(data_rd && autoclr)) |=> (s_q.src & $past(s_q.src)) == $past(s_q.src))
    else $error("interrupt source flag dropped without a clear");

  AST_EVENT_CLEARS_SRC: assert property (
    (reg_wr && reg_addr == GPXT_ADDR_EVENT && !(data_rd && autoclr))
    |=> s_q.src == (($past(s_q.src) & ~$past(reg_wdata)) | $past(src_set)))
    else $error("event write did not clear source flags");

  AST_AUTOCLEAR: assert property (
    (data_rd && autoclr) |=> s_q.src == $past(src_set))
    else $error("auto-clear on data read failed");

  AST_BOOST: assert property (
    (reg_wr && reg_addr == GPXT_ADDR_ADVANCED)
    |=> ##1 boost_on == $past(reg_wdata[GPXT_ADV_BOOST_BIT], 2))
    else $error("boost output does not follow its bit");

  AST_RELEASE: assert property (
    (reg_wr && reg_addr == GPXT_ADDR_IRQ_SOURCE && reg_wdata == 8'hff
     && src_set == 8'h00) |-> ##2 irq_out_n)
    else $error("interrupt not released after clearing all sources");

  AST_FALL_EDGE: assert property (
    (s_q.edge_lower[1:0] == GPXT_EDGE_FALL && s_q.prev_pins[0] && !pins_in[0]
     && !s_q.mask[0]) |=> s_q.src[0] ##1 !irq_out_n)
    else $error("falling edge did not raise the interrupt");

  AST_RESET_QUIET: assert property (
    $fell(rst) |-> irq_out_n && !boost_on && !pin4_drive && !pin4_out
    && reg_rdata == GPXT_RST_FLAGS)
    else $error("outputs not at reset values after reset");

  AST_AUTOCLR_BIT: assert property (
    (reg_wr && reg_addr == GPXT_ADDR_ADVANCED)
    |=> autoclr == $past(reg_wdata[GPXT_ADV_AUTOCLR_BIT]))
    else $error("auto-clear bit not stored from the write");

  AST_IRQ_LEVEL: assert property (
    1'b1 |=> irq_out_n == ~|$past(s_q.src))
    else $error("interrupt output does not follow the source flags");

  AST_RDATA_TABLE: assert property (
    (reg_rd && reg_addr == GPXT_ADDR_PIN4_TABLE) |=> reg_rdata == $past(s_q.table_v))
    else $error("logic table read returned wrong data");

  AST_EVENT_SET: assert property (
    (hits != GPXT_RST_FLAGS)
    |=> (s_q.evt & $past(hits)) == $past(hits))
    else $error("detected edge did not set its event flag");
endmodule
`default_nettype wire

// ===== bench/gpxt_host.sv
// host model issuing register strobes to the tail block
`timescale 1ns/1ps
`default_nettype none
module gpxt_host
(
  // register strobes
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one strobe cycle then one idle cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
  begin
    reg_addr = a;
    reg_wdata = (a == 8'had) ? (d & 8'hfe) : d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
  end
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking testbench for the gpio expander tail block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import gpxt_pkg::*;
;
  logic clk, rst, reg_wr, reg_rd, pin4_out, pin4_drive, boost_on, irq_out_n, rd_pend;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tbl;
  logic [15:0] pins_in;
  logic [1:0] mode;
  logic [7:0] q[$];
  int mismatches = 0;
  int checks_done = 0;
  integer seed;
  gpxt_host h (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  gpxt_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in),
    .low_bank_logic_mode(mode), .pin4_out(pin4_out), .pin4_drive(pin4_drive),
    .boost_on(boost_on), .irq_out_n(irq_out_n));
  task automatic close_out();
  begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
  begin
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
  begin
    q.push_back(e);
    h.acc(1'b0, a, 8'h00);
  end
  endtask
  task automatic wirq(input logic e);
  begin
    repeat (3) @(posedge clk);
    #1;
    chk("irq", {7'h00, e}, {7'h00, irq_out_n});
  end
  endtask
  // read data is settled by the falling edge after the read
  always @(posedge clk) rd_pend <= reg_rd;
  always @(negedge clk)
    if (rd_pend === 1'b1)
      chk("rdata", q.pop_front(), reg_rdata);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #20000;
    mismatches++;
    close_out();
  end
  initial
  begin
    seed = 28;
    rst = 1'b1;
    mode = 2'h0;
    pins_in = {8'($random(seed)), 8'hff};
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    rdx(GPXT_ADDR_PIN4_TABLE, 8'h00);
    rdx(GPXT_ADDR_ADVANCED, 8'h00);
    chk("boost", 8'h00, {7'h00, boost_on});
    tbl = 8'($random(seed));
    h.acc(1'b1, GPXT_ADDR_PIN4_TABLE, tbl);
    rdx(GPXT_ADDR_PIN4_TABLE, tbl);
    for (int m = 0; m < 4; m++)
      for (int n = 0; n < 8; n++)
      begin
        mode = 2'(m);
        pins_in[2:0] = 3'(n);
        repeat (2) @(posedge clk);
        #1;
        chk("pin4", m == 3 ? {7'h00, tbl[n]} : 8'h00, {7'h00, pin4_out});
        chk("drive", {7'h00, m == 3}, {7'h00, pin4_drive});
      end
    h.acc(1'b1, GPXT_ADDR_ADVANCED, 8'hff);
    rdx(GPXT_ADDR_ADVANCED, 8'h06);
    chk("boost", 8'h01, {7'h00, boost_on});
    h.acc(1'b1, GPXT_ADDR_ADVANCED, 8'h02);
    // unmask all pins, falling edges everywhere
    h.acc(1'b1, GPXT_ADDR_IRQ_MASK, 8'h00);
    h.acc(1'b1, GPXT_ADDR_EDGE_UPPER, 8'haa);
    h.acc(1'b1, GPXT_ADDR_EDGE_LOWER, 8'haa);
    for (int k = 0; k < 4; k++)
    begin
      pins_in[7:0] = ~(8'h01 << (2 * k));
      wirq(1'b0);
      pins_in[7:0] = 8'hff;
      rdx(GPXT_ADDR_IRQ_SOURCE, 8'h01 << (2 * k));
      if (k < 2)
      begin
        rdx(GPXT_ADDR_DATA_LOW, 8'hff);
        wirq(1'b0);
        h.acc(1'b1, k ? GPXT_ADDR_EVENT : GPXT_ADDR_IRQ_SOURCE, k ? 8'h04 : 8'hff);
      end
      else if (k == 2)
        rdx(GPXT_ADDR_DATA_HIGH, pins_in[15:8]);
      else
        rdx(GPXT_ADDR_DATA_LOW, 8'hff);
      wirq(1'b1);
      if (k == 1)
        h.acc(1'b1, GPXT_ADDR_ADVANCED, 8'h06);
    end
    rdx(GPXT_ADDR_EVENT, 8'h51);
    rdx(8'h00, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
